// ===== hw/activity_pulse.sv
// Stretches a one-cycle activity event into a visible active-low LED pulse
`timescale 1ns/1ps
module activity_pulse #(
  parameter int CYC = 20000
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_event,
  output logic      o_led_n
);

  localparam int CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Retrigger extends the pulse, so a busy link reads as steady on
  always_comb begin
    cnt_d = cnt_q;
    if (i_event) begin
      cnt_d = CW'(CYC);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q   <= '0;
      o_led_n <= 1'b1;
    end else begin
      cnt_q   <= cnt_d;
      o_led_n <= (cnt_d == '0);
    end
  end

endmodule : activity_pulse

// ===== hw/config_pin_function_mux.sv
// Function selector for four configurable control pins, with Avalon-MM registers
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module config_pin_function_mux #(
  parameter int LED_ON_CYC = pin_mux_pkg::LED_ON_CYC
) (
  input  wire logic                                  i_clk,
  input  wire logic                                  i_rst_n,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0]        i_avs_address,
  input  wire logic                                  i_avs_read,
  input  wire logic                                  i_avs_write,
  input  wire logic [pin_mux_pkg::DATA_W-1:0]        i_avs_writedata,
  input  wire logic [pin_mux_pkg::DATA_W/8-1:0]      i_avs_byteenable,
  output logic      [pin_mux_pkg::DATA_W-1:0]        o_avs_readdata,
  output logic                                       o_avs_waitrequest,
  input  wire logic [pin_mux_pkg::SEL_ALL-1:0]       i_nonvolatile_config,
  input  wire logic                                  i_nonvolatile_valid,
  input  wire pin_mux_pkg::usb_status_type           i_usb,
  input  wire pin_mux_pkg::core_sig_type             i_core,
  input  wire pin_mux_pkg::clk_src_type              i_clk_src,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0]      i_pin_in,
  output logic      [pin_mux_pkg::NUM_PINS-1:0]      o_pin_out,
  output logic      [pin_mux_pkg::NUM_PINS-1:0]      o_pin_oe,
  output logic                                       o_bus_power_sense_in,
  output logic                                       o_suspend_inhibit
);

  localparam int NP = pin_mux_pkg::NUM_PINS;
  localparam int DW = pin_mux_pkg::DATA_W;

  logic [pin_mux_pkg::SEL_ALL-1:0]  sel_q;
  logic [2*NP-1:0]                  gpio_q;
  logic                             ack_q;
  logic [DW-1:0]                    rdata_d;
  logic [DW-1:0]                    status;
  logic                             wr_take;
  logic [NP-1:0]                    pin_s;
  logic [pin_mux_pkg::NUM_LED-1:0]  led_ev;
  logic [pin_mux_pkg::NUM_LED-1:0]  led_n;
  logic                             stamp_q;
  logic                             nv_loaded_q;
  logic [NP-1:0]                    vbus_hit;
  logic [NP-1:0]                    awake_hit;
  logic                             pwr_en_n;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] wd,
                                          input logic [DW/8-1:0] be);
    logic [DW-1:0] res;
    res = old;
    for (int b = 0; b < DW / 8; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then the request is taken
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign wr_take           = i_avs_write && ack_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
    end
  end

  always_comb begin
    status = '0;
    status[pin_mux_pkg::ST_IN_LSB +: NP]   = pin_s;
    status[pin_mux_pkg::ST_SUSPEND]        = i_usb.suspend;
    status[pin_mux_pkg::ST_VBUS]           = o_bus_power_sense_in;
    status[pin_mux_pkg::ST_AWAKE]          = o_suspend_inhibit;
    status[pin_mux_pkg::ST_STAMP]          = stamp_q;
    status[pin_mux_pkg::ST_NV_LOADED]      = nv_loaded_q;
  end

  always_comb begin
    case (i_avs_address)
      pin_mux_pkg::REG_PIN_SEL: rdata_d = DW'(sel_q);
      pin_mux_pkg::REG_GPIO:    rdata_d = DW'(gpio_q);
      pin_mux_pkg::REG_STATUS:  rdata_d = status;
      default:                  rdata_d = '0;
    endcase
  end

  // Sampled in the wait cycle so data stand at the accepting edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read && !ack_q) begin
      o_avs_readdata <= rdata_d;
    end
  end

  // ==========================================================================
  // Selector fields; a nonvolatile load overrides a bus write in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q <= pin_mux_pkg::DEFAULT_SEL;
    end else if (i_nonvolatile_valid) begin
      sel_q <= i_nonvolatile_config;
    end else if (wr_take && i_avs_address == pin_mux_pkg::REG_PIN_SEL) begin
      sel_q <= pin_mux_pkg::SEL_ALL'(merge(DW'(sel_q), i_avs_writedata, i_avs_byteenable));
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nv_loaded_q <= 1'b0;
    end else if (i_nonvolatile_valid) begin
      nv_loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gpio_q <= '0;
    end else if (wr_take && i_avs_address == pin_mux_pkg::REG_GPIO) begin
      gpio_q <= (2*NP)'(merge(DW'(gpio_q), i_avs_writedata, i_avs_byteenable));
    end
  end

  nv_load_a: assert property (i_nonvolatile_valid |=> sel_q == $past(i_nonvolatile_config))
    else $error("selector not loaded from nonvolatile configuration");

  bus_answer_a: assert property ((i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest)
    else $error("bus request not answered within one wait cycle");
  // Read data stand from the accepting edge until the next read
  read_hold_a: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data changed without a read");

  // ==========================================================================
  // Shared sources
  pin_sync #(
    .W (NP)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_pin_in),
    .o_sync  (pin_s)
  );

  assign led_ev   = {i_usb.tx_act || i_usb.rx_act, i_usb.rx_act, i_usb.tx_act};
  assign pwr_en_n = !(i_usb.configured && !i_usb.suspend);

  for (genvar k = 0; k < pin_mux_pkg::NUM_LED; k++) begin : g_led
    activity_pulse #(
      .CYC (LED_ON_CYC)
    ) u_pulse (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_event (led_ev[k]),
      .o_led_n (led_n[k])
    );
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stamp_q <= 1'b0;
    end else if (i_usb.sof) begin
      stamp_q <= !stamp_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_power_sense_in <= 1'b0;
      o_suspend_inhibit    <= 1'b0;
    end else begin
      o_bus_power_sense_in <= |vbus_hit;
      o_suspend_inhibit    <= |awake_hit;
    end
  end

  tx_led_a: assert property (i_usb.tx_act |=> !led_n[0])
    else $error("transmit LED did not go low after activity");
  rx_led_a: assert property (i_usb.rx_act |=> !led_n[1])
    else $error("receive LED did not go low after activity");
  any_led_a: assert property ((i_usb.tx_act || i_usb.rx_act) |=> !led_n[2])
    else $error("combined LED did not go low after activity");
  stamp_toggle_a: assert property (i_usb.sof |=> stamp_q != $past(stamp_q))
    else $error("frame marker did not toggle on start-of-frame");
  stamp_hold_a: assert property (!i_usb.sof |=> stamp_q == $past(stamp_q))
    else $error("frame marker changed without start-of-frame");
  sense_clear_a: assert property (!(|vbus_hit) |=> !o_bus_power_sense_in)
    else $error("bus power sense reported without a sensing pin");

  // ==========================================================================
  // Per-pin function decode
  for (genvar i = 0; i < NP; i++) begin : g_pin
    pin_mux_pkg::pin_func_type fn;
    logic                      out_d;
    logic                      oe_d;
    logic                      out_q;
    logic                      oe_q;
    logic                      is_clk;
    logic                      clk_sel;

    assign fn = pin_mux_pkg::pin_func_type'(sel_q[i*pin_mux_pkg::SEL_W +: pin_mux_pkg::SEL_W]);

    always_comb begin
      out_d = 1'b0;
      oe_d  = 1'b1;
      case (fn)
        pin_mux_pkg::F_TRISTATE:        oe_d  = 1'b0;
        pin_mux_pkg::F_DRIVE_1:         out_d = 1'b1;
        pin_mux_pkg::F_DRIVE_0:         out_d = 1'b0;
        pin_mux_pkg::F_RS485_EN:        out_d = i_core.tx_busy;
        pin_mux_pkg::F_PWR_EN_N:        out_d = pwr_en_n;
        pin_mux_pkg::F_TX_LED_N:        out_d = led_n[0];
        pin_mux_pkg::F_RX_LED_N:        out_d = led_n[1];
        pin_mux_pkg::F_ANY_LED_N:       out_d = led_n[2];
        pin_mux_pkg::F_SLEEP_N:         out_d = !i_usb.suspend;
        pin_mux_pkg::F_GPIO: begin
          out_d = gpio_q[pin_mux_pkg::GPIO_OUT_LSB + i];
          oe_d  = gpio_q[pin_mux_pkg::GPIO_DIR_LSB + i];
        end
        pin_mux_pkg::F_CHARGER:         out_d = i_core.charger;
        pin_mux_pkg::F_CHARGER_N:       out_d = !i_core.charger;
        pin_mux_pkg::F_WR_STROBE_N:     out_d = i_core.wr_strobe_n;
        pin_mux_pkg::F_RD_STROBE_N:     out_d = i_core.rd_strobe_n;
        pin_mux_pkg::F_BUS_POWER_SENSE: oe_d  = 1'b0;
        pin_mux_pkg::F_TIME_STAMP:      out_d = stamp_q;
        pin_mux_pkg::F_KEEP_AWAKE_N:    oe_d  = 1'b0;
        pin_mux_pkg::F_CLK_FAST:        out_d = 1'b0;
        pin_mux_pkg::F_CLK_MID:         out_d = 1'b0;
        pin_mux_pkg::F_CLK_SLOW:        out_d = 1'b0;
        // Unused codes float the pad rather than drive a guess
        default:                        oe_d  = 1'b0;
      endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        out_q <= 1'b0;
        oe_q  <= 1'b0;
      end else begin
        out_q <= out_d;
        oe_q  <= oe_d;
      end
    end

    // Clocks cannot pass a 20 MHz flop; they are gated straight from the divider
    assign is_clk  = fn inside {pin_mux_pkg::F_CLK_FAST, pin_mux_pkg::F_CLK_MID, pin_mux_pkg::F_CLK_SLOW};
    assign clk_sel = (fn == pin_mux_pkg::F_CLK_FAST) ? i_clk_src.fast :
                     (fn == pin_mux_pkg::F_CLK_MID)  ? i_clk_src.mid  : i_clk_src.slow;

    assign o_pin_out[i] = is_clk ? (clk_sel && !i_usb.suspend) : out_q;
    assign o_pin_oe[i]  = oe_q;
    assign vbus_hit[i]  = (fn == pin_mux_pkg::F_BUS_POWER_SENSE) && pin_s[i];
    assign awake_hit[i] = (fn == pin_mux_pkg::F_KEEP_AWAKE_N) && !pin_s[i];

    // Attempts start out of reset; one edge after release the flops still hold reset values
    property follows_p(pin_mux_pkg::pin_func_type f, logic v);
      (i_rst_n && fn == f) ##1 (fn == f) |-> (o_pin_out[i] == $past(v)) && o_pin_oe[i];
    endproperty

    tristate_pin_a: assert property ((fn == pin_mux_pkg::F_TRISTATE) [*2] |-> !o_pin_oe[i])
      else $error("tri-state pin is driven");
    drive_const_a: assert property ((fn == pin_mux_pkg::F_DRIVE_0) [*2] |-> o_pin_oe[i] && !o_pin_out[i])
      else $error("constant zero pin not driven low");
    drive_one_a: assert property ((fn == pin_mux_pkg::F_DRIVE_1) [*2] |-> o_pin_oe[i] && o_pin_out[i])
      else $error("constant one pin not driven high");
    rs485_enable_a: assert property (follows_p(pin_mux_pkg::F_RS485_EN, i_core.tx_busy))
      else $error("transmit enable does not follow transmitter");
    power_enable_a: assert property (follows_p(pin_mux_pkg::F_PWR_EN_N,
                                               !(i_usb.configured && !i_usb.suspend)))
      else $error("power enable level wrong");
    sleep_level_a: assert property (follows_p(pin_mux_pkg::F_SLEEP_N, !i_usb.suspend))
      else $error("sleep indication wrong");
    charger_inv_a: assert property (follows_p(pin_mux_pkg::F_CHARGER_N, !i_core.charger))
      else $error("inverted charger indication wrong");
    charger_det_a: assert property (follows_p(pin_mux_pkg::F_CHARGER, i_core.charger))
      else $error("charger indication wrong");
    write_strobe_a: assert property (follows_p(pin_mux_pkg::F_WR_STROBE_N, i_core.wr_strobe_n))
      else $error("write strobe not passed to pin");
    read_strobe_a: assert property (follows_p(pin_mux_pkg::F_RD_STROBE_N, i_core.rd_strobe_n))
      else $error("read strobe not passed to pin");
    // Enable lags the selector by one edge, so the option must stand for two
    clock_stop_a: assert property (is_clk ##1 (is_clk && i_usb.suspend)
                                   |-> o_pin_oe[i] && !o_pin_out[i])
      else $error("clock output toggles during suspend");
    clock_pass_a: assert property (!i_usb.suspend |->
                                   (fn != pin_mux_pkg::F_CLK_FAST || o_pin_out[i] == i_clk_src.fast)
                                   && (fn != pin_mux_pkg::F_CLK_MID || o_pin_out[i] == i_clk_src.mid)
                                   && (fn != pin_mux_pkg::F_CLK_SLOW || o_pin_out[i] == i_clk_src.slow))
      else $error("clock option does not carry its clock");
    gpio_pin_a: assert property ((fn == pin_mux_pkg::F_GPIO) [*2]
                                 |-> o_pin_oe[i] == $past(gpio_q[pin_mux_pkg::GPIO_DIR_LSB + i])
                                     && (!o_pin_oe[i] || o_pin_out[i] == $past(gpio_q[i])))
      else $error("general-purpose pin mismatch");
    input_undriven_a: assert property (
        (fn inside {pin_mux_pkg::F_BUS_POWER_SENSE, pin_mux_pkg::F_KEEP_AWAKE_N}) [*2] |-> !o_pin_oe[i])
      else $error("input option pin is driven");
    keep_awake_a: assert property ((fn == pin_mux_pkg::F_KEEP_AWAKE_N) && !pin_s[i]
                                   |=> o_suspend_inhibit)
      else $error("keep-awake input did not inhibit suspend");

    sense_path_a: assert property ((fn == pin_mux_pkg::F_BUS_POWER_SENSE) && pin_s[i]
                                   |=> o_bus_power_sense_in)
      else $error("bus power sense input not reported");
  end

  // ==========================================================================
  // Scenario coverage
  nv_load_c: cover property (i_nonvolatile_valid ##1 !i_nonvolatile_valid);
  read_done_c: cover property (i_avs_read && !o_avs_waitrequest);
  gpio_out_c: cover property (g_pin[0].fn == pin_mux_pkg::F_GPIO && o_pin_oe[0]);
  inhibit_c: cover property ($rose(o_suspend_inhibit));
  // Gated clocks in suspend are the case most easily left unexercised
  clock_stop_c: cover property (g_pin[1].is_clk && i_usb.suspend);

endmodule : config_pin_function_mux

// ===== hw/pin_mux_pkg.sv
// Shared codes, register map, carriers and timing of the configurable pin selector
package pin_mux_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_PINS = 4;
  localparam int SEL_W    = 5;
  localparam int SEL_ALL  = NUM_PINS * SEL_W;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;
  localparam int NUM_LED  = 3;

  // ==========================================================================
  // Pin function codes
  typedef enum logic [SEL_W-1:0] {
    F_TRISTATE        = 5'h00,
    F_DRIVE_1         = 5'h01,
    F_DRIVE_0         = 5'h02,
    F_RS485_EN        = 5'h03,
    F_PWR_EN_N        = 5'h04,
    F_TX_LED_N        = 5'h05,
    F_RX_LED_N        = 5'h06,
    F_ANY_LED_N       = 5'h07,
    F_SLEEP_N         = 5'h08,
    F_CLK_FAST        = 5'h09,
    F_CLK_MID         = 5'h0a,
    F_CLK_SLOW        = 5'h0b,
    F_GPIO            = 5'h0c,
    F_CHARGER         = 5'h0d,
    F_CHARGER_N       = 5'h0e,
    F_WR_STROBE_N     = 5'h0f,
    F_RD_STROBE_N     = 5'h10,
    F_BUS_POWER_SENSE = 5'h11,
    F_TIME_STAMP      = 5'h12,
    F_KEEP_AWAKE_N    = 5'h13
  } pin_func_type;

  localparam logic [SEL_ALL-1:0] DEFAULT_SEL = {F_SLEEP_N, F_TX_LED_N, F_RX_LED_N, F_RS485_EN};

  // ==========================================================================
  // Register map (byte addresses) and fields
  localparam logic [ADDR_W-1:0] REG_PIN_SEL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_GPIO    = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h8;
  localparam int GPIO_OUT_LSB = 0;
  localparam int GPIO_DIR_LSB = 4;
  localparam int ST_IN_LSB    = 0;
  localparam int ST_SUSPEND   = 4;
  localparam int ST_VBUS      = 5;
  localparam int ST_AWAKE     = 6;
  localparam int ST_STAMP     = 7;
  localparam int ST_NV_LOADED = 8;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ     = 20_000_000;
  localparam int LED_ON_US  = 1000;
  localparam int LED_ON_CYC = LED_ON_US * (CLK_HZ / 1_000_000);

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic configured;
    logic suspend;
    logic tx_act;
    logic rx_act;
    logic sof;
  } usb_status_type;

  typedef struct packed {
    logic tx_busy;
    logic charger;
    logic wr_strobe_n;
    logic rd_strobe_n;
  } core_sig_type;

  typedef struct packed {
    logic fast;
    logic mid;
    logic slow;
  } clk_src_type;

endpackage : pin_mux_pkg

// ===== hw/pin_sync.sv
// Two-flop synchroniser for the pad inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : pin_sync

// ===== verif/pad_board.sv
// Board-side model of the four configurable pads
`timescale 1ns/1ps
module pad_board (
  input  wire logic       i_pull_dn,
  input  wire logic [3:0] i_pin_out,
  input  wire logic [3:0] i_pin_oe,
  input  wire logic [3:0] i_drv_en,
  input  wire logic [3:0] i_drv_val,
  output logic      [3:0] o_pad
);
  // ==========================================================================
  // Pad resolution
  // Released pad sits at the pull level; both driving gives unknown on purpose
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (i_pin_oe[k] && i_drv_en[k]) begin
        o_pad[k] = 1'hx;
      end else if (i_pin_oe[k]) begin
        o_pad[k] = i_pin_out[k];
      end else if (i_drv_en[k]) begin
        o_pad[k] = i_drv_val[k];
      end else begin
        o_pad[k] = ~i_pull_dn;
      end
    end
  end
endmodule : pad_board

// ===== verif/testbench.sv
// Self-checking bench for the configurable pin selector
`timescale 1ns/1ps
module testbench;
  localparam int LED_CYC = 8;
  logic                        i_clk, i_rst_n, rd_s, wr_s, wait_r, nv_vld, sense, inhibit;
  logic [3:0]                  adr, pad, pout, poe, drv_en, drv_val;
  logic [31:0]                 wd, rdat, rdat_w;
  logic [19:0]                 nv_cfg;
  pin_mux_pkg::usb_status_type usb;
  pin_mux_pkg::core_sig_type   core;
  pin_mux_pkg::clk_src_type    cs;
  int                          num_errors, n_tests;

  config_pin_function_mux #(.LED_ON_CYC(LED_CYC)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdat_w), .o_avs_waitrequest(wait_r),
    .i_nonvolatile_config(nv_cfg), .i_nonvolatile_valid(nv_vld), .i_usb(usb), .i_core(core),
    .i_clk_src(cs), .i_pin_in(pad), .o_pin_out(pout), .o_pin_oe(poe),
    .o_bus_power_sense_in(sense), .o_suspend_inhibit(inhibit));
  pad_board board (.i_pull_dn(1'h0), .i_pin_out(pout), .i_pin_oe(poe), .i_drv_en(drv_en),
    .i_drv_val(drv_val), .o_pad(pad));

  // ==========================================================================
  // Clocks and time-zero values
  // Half periods chosen so source edges never meet a sampling edge
  always #25 i_clk = ~i_clk;
  always #20.83 cs.fast = ~cs.fast;
  always #41.67 cs.mid = ~cs.mid;
  always #83.33 cs.slow = ~cs.slow;
  initial begin
    {i_clk, i_rst_n, rd_s, wr_s, nv_vld, usb, cs} = '0;
    {adr, wd, nv_cfg, drv_en, drv_val, num_errors, n_tests} = '0;
    core = 4'h3;
  end

  // ==========================================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= ~w;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (wait_r !== 1'h0 && n < 50);
    rdat = rdat_w;
    if (n >= 50) begin
      chk(1'h0, 1'h1, "bus timeout");
      tally_and_finish();
    end
    wr_s <= 1'h0;
    rd_s <= 1'h0;
  endtask : bus

  task automatic set_sel(input pin_mux_pkg::pin_func_type p3, p2, p1, p0);
    bus(1'h1, pin_mux_pkg::REG_PIN_SEL, {12'h0, p3, p2, p1, p0});
    cyc(3);
  endtask : set_sel

  // ==========================================================================
  // Scenarios
  task automatic t_defaults();
    core.tx_busy <= 1'h1;
    cyc(3);
    chk(poe, 4'hf, "default enables");
    chk(pout, 4'hf, "default levels");
    core.tx_busy <= 1'h0;
    cyc(2);
    chk(pout, 4'he, "rs485 enable drop");
    bus(1'h0, pin_mux_pkg::REG_PIN_SEL, 32'h0);
    chk(rdat, pin_mux_pkg::DEFAULT_SEL, "default selectors");
    bus(1'h0, 4'hc, 32'h0);
    chk(rdat, 32'h0, "unmapped read");
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_static();
    set_sel(pin_mux_pkg::F_RS485_EN, pin_mux_pkg::F_DRIVE_0, pin_mux_pkg::F_DRIVE_1, pin_mux_pkg::F_TRISTATE);
    chk(poe, 4'he, "float pin driven");
    chk(pout[2:1], 2'h1, "constant levels");
    core.tx_busy <= 1'h1;
    cyc(2);
    chk(pout[3], 1'h1, "rs485 enable on pin 3");
    core.tx_busy <= 1'h0;
    $display("test static done");
  endtask : t_static

  task automatic t_levels();
    set_sel(pin_mux_pkg::F_CHARGER_N, pin_mux_pkg::F_CHARGER, pin_mux_pkg::F_SLEEP_N, pin_mux_pkg::F_PWR_EN_N);
    for (int i = 0; i < 4; i++) begin
      usb.configured <= i[0];
      usb.suspend <= i[1];
      core.charger <= i[0] ^ i[1];
      cyc(2);
      chk(pout[0], {~i[0] | i[1]}, "power enable level");
      chk(pout[1], {~i[1]}, "sleep level");
      chk(pout[3:2], {~(i[0] ^ i[1]), i[0] ^ i[1]}, "charger levels");
    end
    usb.suspend <= 1'h0;
    set_sel(pin_mux_pkg::F_TRISTATE, pin_mux_pkg::F_TRISTATE, pin_mux_pkg::F_RD_STROBE_N,
            pin_mux_pkg::F_WR_STROBE_N);
    for (int i = 0; i < 4; i++) begin
      core.wr_strobe_n <= i[0];
      core.rd_strobe_n <= i[1];
      cyc(2);
      chk(pout[1:0], i[1:0], "strobe levels");
    end
    $display("test levels done");
  endtask : t_levels

  task automatic t_leds();
    set_sel(pin_mux_pkg::F_TRISTATE, pin_mux_pkg::F_ANY_LED_N, pin_mux_pkg::F_RX_LED_N, pin_mux_pkg::F_TX_LED_N);
    usb.tx_act <= 1'h1;
    cyc(1);
    usb.tx_act <= 1'h0;
    cyc(2);
    chk(pout[2:0], 3'h2, "transmit pulse");
    cyc(LED_CYC + 4);
    chk(pout[2:0], 3'h7, "leds idle");
    usb.rx_act <= 1'h1;
    cyc(1);
    usb.rx_act <= 1'h0;
    cyc(2);
    chk(pout[2:0], 3'h1, "receive pulse");
    $display("test leds done");
  endtask : t_leds

  task automatic t_clocks();
    set_sel(pin_mux_pkg::F_CLK_SLOW, pin_mux_pkg::F_CLK_MID, pin_mux_pkg::F_CLK_FAST, pin_mux_pkg::F_TRISTATE);
    repeat (16) begin
      @(negedge i_clk);
      chk(pout[3:1], {cs.slow, cs.mid, cs.fast}, "clock outputs");
    end
    @(posedge i_clk);
    usb.suspend <= 1'h1;
    repeat (16) begin
      @(negedge i_clk);
      chk(pout[3:1], 3'h0, "clocks in suspend");
    end
    @(posedge i_clk);
    usb.suspend <= 1'h0;
    $display("test clocks done");
  endtask : t_clocks

  task automatic t_inputs();
    logic p;
    set_sel(pin_mux_pkg::F_GPIO, pin_mux_pkg::F_KEEP_AWAKE_N, pin_mux_pkg::F_BUS_POWER_SENSE,
            pin_mux_pkg::F_TIME_STAMP);
    bus(1'h1, pin_mux_pkg::REG_GPIO, 32'h88);
    cyc(3);
    chk(poe, 4'h9, "input pins released");
    chk(pout[3], 1'h1, "gpio drives one");
    drv_en <= 4'h6;
    drv_val <= 4'h2;
    cyc(5);
    chk({sense, inhibit}, 2'h3, "sense and keep awake");
    bus(1'h0, pin_mux_pkg::REG_STATUS, 32'h0);
    chk(rdat[8:0], 9'h06a, "status inputs");
    drv_val <= 4'h4;
    cyc(5);
    chk({sense, inhibit}, 2'h0, "sense and keep awake off");
    p = pout[0];
    usb.sof <= 1'h1;
    cyc(1);
    usb.sof <= 1'h0;
    cyc(2);
    chk(pout[0], {~p}, "frame marker toggle");
    drv_en <= 4'h0;
    $display("test inputs done");
  endtask : t_inputs

  task automatic t_nvload();
    nv_cfg <= {pin_mux_pkg::F_DRIVE_0, pin_mux_pkg::F_DRIVE_1, pin_mux_pkg::F_DRIVE_0, pin_mux_pkg::F_DRIVE_1};
    nv_vld <= 1'h1;
    cyc(1);
    nv_vld <= 1'h0;
    cyc(3);
    chk({poe, pout}, 8'hf5, "stored config on pins");
    bus(1'h0, pin_mux_pkg::REG_STATUS, 32'h0);
    chk(rdat[pin_mux_pkg::ST_NV_LOADED], 1'h1, "loaded flag");
    $display("test nvload done");
  endtask : t_nvload

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'h1;
    t_defaults();
    t_static();
    t_levels();
    t_leds();
    t_clocks();
    t_inputs();
    t_nvload();
    tally_and_finish();
  end
endmodule : testbench
